// ### rtl/line_start_trigger.sv
/*
  Line-start trigger controller: free-run line generator with rate clamp,
  external/CC1 trigger path with pulse-width filter and edge selection,
  optional rescaler, strobe output and a small register port.
  Assumes trigPin and cc1Pin are asynchronous levels; the register master
  follows the single-cycle strobe protocol on sys_clk.
*/
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps

module line_start_trigger
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic trigPin,
  input wire logic cc1Pin,
  output logic lineStart,
  output logic strobeOut
);

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic trigModeOn_ff;
  logic srcCc1_ff;
  logic [1:0] activation_ff;
  logic rescalerOn_ff;
  logic [2:0] filterSel_ff;
  logic [trig_pkg::PERIOD_W-1:0] linePeriod_ff;
  logic [trig_pkg::PERIOD_W-1:0] minPeriod_ff;
  logic [trig_pkg::RATE_W-1:0] rate_ff;
  logic [trig_pkg::PERIOD_W-1:0] strobeWidth_ff;
  logic [31:0] lineCount_ff;

  // address decode
  wire logic selCtrl = regAddr == trig_pkg::CTRL_OFS;
  wire logic selLine = regAddr == trig_pkg::LINE_PERIOD_OFS;
  wire logic selMin = regAddr == trig_pkg::MIN_PERIOD_OFS;
  wire logic selRate = regAddr == trig_pkg::RESCALE_RATE_OFS;
  wire logic selStrobe = regAddr == trig_pkg::STROBE_WIDTH_OFS;
  wire logic selCount = regAddr == trig_pkg::LINE_COUNT_OFS;
  wire logic selAvg = regAddr == trig_pkg::AVG_PERIOD_OFS;

  // a written factor is held inside its legal range
  wire logic [trig_pkg::RATE_W-1:0] wrRate = regWdata[trig_pkg::RATE_W-1:0];
  wire logic rateHigh = (|regWdata[31:trig_pkg::RATE_W]) || (wrRate > trig_pkg::RATE_MAX);
  wire logic [trig_pkg::RATE_W-1:0] nxt_rate = rateHigh ? trig_pkg::RATE_MAX :
                                               (wrRate < trig_pkg::RATE_MIN) ? trig_pkg::RATE_MIN : wrRate;

  // filter codes above 5 saturate at the longest filter
  wire logic [2:0] wrFilt = regWdata[trig_pkg::CTRL_FILT_LSB +: 3];
  wire logic [2:0] nxt_filterSel = (wrFilt > trig_pkg::FILT_MAX) ? trig_pkg::FILT_MAX : wrFilt;

  // register writes; unmapped offsets are ignored
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      trigModeOn_ff <= 1'b0;
      srcCc1_ff <= 1'b0;
      activation_ff <= 2'h0;
      rescalerOn_ff <= 1'b0;
      filterSel_ff <= 3'h0;
      linePeriod_ff <= trig_pkg::LINE_PERIOD_RST;
      minPeriod_ff <= trig_pkg::MIN_PERIOD_RST;
      rate_ff <= trig_pkg::RATE_RST;
      strobeWidth_ff <= trig_pkg::STROBE_WIDTH_RST;
    end
    else if (regWr)
    begin
      if (selCtrl)
      begin
        trigModeOn_ff <= regWdata[trig_pkg::CTRL_MODE_BIT];
        srcCc1_ff <= regWdata[trig_pkg::CTRL_SRC_BIT];
        activation_ff <= regWdata[trig_pkg::CTRL_ACT_LSB +: 2];
        // bit value 1 enables the rescaler, 0 disables it
        rescalerOn_ff <= regWdata[trig_pkg::CTRL_RSC_BIT];
        filterSel_ff <= nxt_filterSel;
      end
      if (selLine)
      begin
        linePeriod_ff <= regWdata[trig_pkg::PERIOD_W-1:0];
      end
      if (selMin)
      begin
        minPeriod_ff <= regWdata[trig_pkg::PERIOD_W-1:0];
      end
      if (selRate)
      begin
        rate_ff <= nxt_rate;
      end
      if (selStrobe)
      begin
        strobeWidth_ff <= regWdata[trig_pkg::PERIOD_W-1:0];
      end
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  logic [trig_pkg::PERIOD_W-1:0] avgPeriod;

  wire logic [31:0] ctrlRd = {24'h000000, filterSel_ff, rescalerOn_ff, activation_ff, srcCc1_ff, trigModeOn_ff};
  wire logic [31:0] rdMux = selCtrl ? ctrlRd :
                            selLine ? {8'h00, linePeriod_ff} :
                            selMin ? {8'h00, minPeriod_ff} :
                            selRate ? {9'h000, rate_ff} :
                            selStrobe ? {8'h00, strobeWidth_ff} :
                            selCount ? lineCount_ff :
                            selAvg ? {8'h00, avgPeriod} : 32'h00000000;

  // data stand only in the cycle after the read strobe, zero otherwise
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      regRdata <= 32'h00000000;
    end
    else
    begin
      regRdata <= regRd ? rdMux : 32'h00000000;
    end
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic trigMeta_ff;
  logic trigSync_ff;
  logic cc1Meta_ff;
  logic cc1Sync_ff;

  // both pins are asynchronous to sys_clk
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      trigMeta_ff <= 1'b0;
      trigSync_ff <= 1'b0;
      cc1Meta_ff <= 1'b0;
      cc1Sync_ff <= 1'b0;
    end
    else
    begin
      trigMeta_ff <= trigPin;
      trigSync_ff <= trigMeta_ff;
      cc1Meta_ff <= cc1Pin;
      cc1Sync_ff <= cc1Meta_ff;
    end
  end

  // ****************************************************************
  // pulse-width filter and edge select
  // ****************************************************************
  localparam logic [7:0] PULSE_LAST = 8'(trig_pkg::MIN_PULSE_CYC - 1);

  logic filtLevel_ff;
  logic [7:0] stableCnt_ff;

  // source chosen before filtering, so a switch is filtered too
  wire logic srcLevel = srcCc1_ff ? cc1Sync_ff : trigSync_ff;
  wire logic levelDiffers = srcLevel != filtLevel_ff;
  wire logic accept = levelDiffers && (stableCnt_ff == PULSE_LAST);

  // a new level is taken only after it held for the full 1 us
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      filtLevel_ff <= 1'b0;
      stableCnt_ff <= 8'h00;
    end
    else if (!levelDiffers || accept)
    begin
      filtLevel_ff <= accept ? srcLevel : filtLevel_ff;
      stableCnt_ff <= 8'h00;
    end
    else
    begin
      stableCnt_ff <= stableCnt_ff + 8'h01;
    end
  end

  // activation chooses which filtered transitions count
  wire logic riseEvt = accept && srcLevel;
  wire logic fallEvt = accept && !srcLevel;
  wire logic edgeEvt = (activation_ff == trig_pkg::ACT_RISING) ? riseEvt :
                       (activation_ff == trig_pkg::ACT_FALLING) ? fallEvt :
                       (activation_ff == trig_pkg::ACT_BOTH) ? (riseEvt || fallEvt) : riseEvt;

  // ****************************************************************
  // rescaler
  // ****************************************************************
  logic rescaledEvt;
  wire logic rescalerRun = trigModeOn_ff && rescalerOn_ff;

  // averaged period divided by the factor drives rescaled triggers
  trig_rescaler u_rescaler
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .enable(rescalerRun),
    .filterSel(filterSel_ff),
    .rate(rate_ff),
    .minPeriod(minPeriod_ff),
    .inEvent(edgeEvt),
    .outEvent(rescaledEvt),
    .avgPeriod(avgPeriod)
  );

  // ****************************************************************
  // free-run line generator
  // ****************************************************************
  logic [trig_pkg::PERIOD_W-1:0] freeCnt_ff;

  // programmed period used while it is no faster than the limit
  // faster settings are clamped to the minimum period
  wire logic [trig_pkg::PERIOD_W-1:0] freePeriod = trig_pkg::maxPeriod(linePeriod_ff, minPeriod_ff);
  wire logic freeFire = !trigModeOn_ff && (freeCnt_ff >= freePeriod - 24'h000001);

  // counter only runs with trigger mode off
  always_ff @(posedge sys_clk)
  begin
    if (rst || trigModeOn_ff || freeFire)
    begin
      freeCnt_ff <= '0;
    end
    else
    begin
      freeCnt_ff <= freeCnt_ff + 24'h000001;
    end
  end

  // ****************************************************************
  // line start select
  // ****************************************************************
  // with the rescaler off, one line per recognised event; the partner paces the events
  wire logic trigFire = trigModeOn_ff && (rescalerOn_ff ? rescaledEvt : edgeEvt);
  wire logic nxt_lineStart = freeFire || trigFire;

  // line start pulse and line counter
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      lineStart <= 1'b0;
      lineCount_ff <= 32'h00000000;
    end
    else
    begin
      lineStart <= nxt_lineStart;
      lineCount_ff <= nxt_lineStart ? lineCount_ff + 32'h00000001 : lineCount_ff;
    end
  end

  // ****************************************************************
  // strobe output
  // ****************************************************************
  logic [trig_pkg::PERIOD_W-1:0] strobeCnt_ff;

  // each line start restarts the strobe for strobeWidth cycles
  wire logic strobeEnd = strobeCnt_ff <= 24'h000001;

  // a zero width keeps the strobe low; a retrigger extends the pulse
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      strobeCnt_ff <= '0;
      strobeOut <= 1'b0;
    end
    else if (lineStart)
    begin
      strobeCnt_ff <= strobeWidth_ff;
      strobeOut <= strobeWidth_ff != 24'h000000;
    end
    else if (strobeEnd)
    begin
      strobeCnt_ff <= '0;
      strobeOut <= 1'b0;
    end
    else
    begin
      strobeCnt_ff <= strobeCnt_ff - 24'h000001;
    end
  end

endmodule // line_start_trigger

// ### rtl/trig_pkg.sv
/*
  Shared constants for the line-start trigger controller: register
  offsets, control field positions, reset values, timing counts and the
  activation encoding.
  Assumes a single 250 MHz system clock; periods are counted in its cycles.
*/
package trig_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int MIN_PULSE_NS = 1000;
  // least time, so round up to whole cycles
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // widths and fixed-point formats
  // ****************************************************************
  localparam int PERIOD_W = 24;
  localparam int RATE_W = 23;
  localparam int RATE_FRAC = 16;
  localparam int AVG_FRAC = 9;
  localparam int FILT_BASE = 4;
  localparam int DIV_STEPS = PERIOD_W + RATE_FRAC;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LINE_PERIOD_OFS = 8'h04;
  localparam logic [7:0] MIN_PERIOD_OFS = 8'h08;
  localparam logic [7:0] RESCALE_RATE_OFS = 8'h0c;
  localparam logic [7:0] STROBE_WIDTH_OFS = 8'h10;
  localparam logic [7:0] LINE_COUNT_OFS = 8'h14;
  localparam logic [7:0] AVG_PERIOD_OFS = 8'h18;

  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_SRC_BIT = 1;
  localparam int CTRL_ACT_LSB = 2;
  localparam int CTRL_RSC_BIT = 4;
  localparam int CTRL_FILT_LSB = 5;

  // ****************************************************************
  // reset values and limits
  // ****************************************************************
  localparam logic [PERIOD_W-1:0] LINE_PERIOD_RST = 24'h0061a8;
  localparam logic [PERIOD_W-1:0] MIN_PERIOD_RST = 24'h0007d0;
  localparam logic [PERIOD_W-1:0] STROBE_WIDTH_RST = 24'h0000fa;
  localparam logic [RATE_W-1:0] RATE_RST = 23'h010000;
  localparam logic [RATE_W-1:0] RATE_MIN = 23'h000290;
  localparam logic [RATE_W-1:0] RATE_MAX = 23'h640000;
  localparam logic [2:0] FILT_MAX = 3'h5;

  typedef enum logic [1:0] {ACT_RISING, ACT_FALLING, ACT_BOTH} act_t;

  // larger of a period and its floor, never below one cycle
  function automatic logic [PERIOD_W-1:0] maxPeriod(input logic [PERIOD_W-1:0] a,
                                                     input logic [PERIOD_W-1:0] b);
    logic [PERIOD_W-1:0] m;
    m = (a > b) ? a : b;
    return (m == 24'h000000) ? 24'h000001 : m;
  endfunction

endpackage

// ### rtl/trig_rescaler.sv
/*
  Trigger rescaler: averages the input trigger period over a selectable
  filter length and emits triggers at the input rate times a fixed-point
  factor.
  Assumes inEvent is a one-cycle pulse on sys_clk and rate is within limits.
*/
`timescale 1ns/100ps

module trig_rescaler
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [2:0] filterSel,
  input wire logic [trig_pkg::RATE_W-1:0] rate,
  input wire logic [trig_pkg::PERIOD_W-1:0] minPeriod,
  input wire logic inEvent,
  output logic outEvent,
  output logic [trig_pkg::PERIOD_W-1:0] avgPeriod
);

  typedef enum logic {DIV_IDLE, DIV_RUN} div_t;

  localparam int AW = trig_pkg::PERIOD_W + trig_pkg::AVG_FRAC;
  localparam int DW = trig_pkg::DIV_STEPS;

  logic [trig_pkg::PERIOD_W-1:0] inCnt_ff;
  logic seen_ff;
  logic haveAvg_ff;
  logic [AW-1:0] acc_ff;
  div_t divState_ff;
  logic [5:0] divCnt_ff;
  logic [DW-1:0] dvd_ff;
  logic [trig_pkg::PERIOD_W-1:0] rem_ff;
  logic [trig_pkg::PERIOD_W-1:0] outPeriod_ff;
  logic outValid_ff;
  logic [trig_pkg::PERIOD_W-1:0] outCnt_ff;

  // ****************************************************************
  // period measurement and averaging
  // ****************************************************************
  // exponential average, length 2^(4+sel) = filter factor
  wire logic [trig_pkg::PERIOD_W-1:0] inPeriod = inCnt_ff + 24'h000001;
  wire logic [AW:0] diff = {1'b0, inPeriod, 9'h000} - {1'b0, acc_ff};
  wire logic [3:0] shiftAmt = 4'(trig_pkg::FILT_BASE) + {1'b0, filterSel};
  wire logic [AW:0] step = $signed(diff) >>> shiftAmt;
  wire logic [AW-1:0] nxt_acc = acc_ff + step[AW-1:0];
  wire logic stale = &inCnt_ff;

  assign avgPeriod = acc_ff[AW-1:trig_pkg::AVG_FRAC];

  // stale input (counter saturated) drops the average so output stops
  always_ff @(posedge sys_clk)
  begin
    if (rst || !enable)
    begin
      inCnt_ff <= '0;
      seen_ff <= 1'b0;
      haveAvg_ff <= 1'b0;
      acc_ff <= '0;
    end
    else if (inEvent)
    begin
      inCnt_ff <= '0;
      seen_ff <= 1'b1;
      haveAvg_ff <= seen_ff;
      acc_ff <= haveAvg_ff ? nxt_acc : (seen_ff ? {inPeriod, 9'h000} : acc_ff);
    end
    else
    begin
      inCnt_ff <= stale ? inCnt_ff : inCnt_ff + 24'h000001;
      haveAvg_ff <= haveAvg_ff && !stale;
    end
  end

  // ****************************************************************
  // output period = average / rate, restoring divider
  // ****************************************************************
  // factor applied as a division of the averaged period
  wire logic [trig_pkg::PERIOD_W-1:0] remSh = {rem_ff[trig_pkg::PERIOD_W-2:0], dvd_ff[DW-1]};
  wire logic ge = remSh >= {1'b0, rate};
  wire logic [trig_pkg::PERIOD_W-1:0] remNx = ge ? remSh - {1'b0, rate} : remSh;
  wire logic [DW-1:0] dvdNx = {dvd_ff[DW-2:0], ge};
  wire logic [trig_pkg::PERIOD_W-1:0] quotSat = (|dvdNx[DW-1:trig_pkg::PERIOD_W]) ? '1 :
                                                dvdNx[trig_pkg::PERIOD_W-1:0];

  // recomputes continuously so rate or average changes take effect within two 41-cycle passes
  always_ff @(posedge sys_clk)
  begin
    if (rst || !haveAvg_ff)
    begin
      divState_ff <= DIV_IDLE;
      divCnt_ff <= '0;
      dvd_ff <= '0;
      rem_ff <= '0;
      outPeriod_ff <= '0;
      outValid_ff <= 1'b0;
    end
    else
    begin
      case (divState_ff)
        DIV_IDLE:
        begin
          dvd_ff <= {avgPeriod, 16'h0000};
          rem_ff <= '0;
          divCnt_ff <= 6'(DW);
          divState_ff <= DIV_RUN;
        end
        DIV_RUN:
        begin
          dvd_ff <= dvdNx;
          rem_ff <= remNx;
          divCnt_ff <= divCnt_ff - 6'h01;
          if (divCnt_ff == 6'h01)
          begin
            outPeriod_ff <= trig_pkg::maxPeriod(quotSat, minPeriod);
            outValid_ff <= 1'b1;
            divState_ff <= DIV_IDLE;
          end
        end
        default:
        begin
          divState_ff <= DIV_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // rescaled trigger generator
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst || !outValid_ff || !haveAvg_ff)
    begin
      outCnt_ff <= '0;
      outEvent <= 1'b0;
    end
    else if (outCnt_ff >= outPeriod_ff - 24'h000001)
    begin
      outCnt_ff <= '0;
      outEvent <= 1'b1;
    end
    else
    begin
      outCnt_ff <= outCnt_ff + 24'h000001;
      outEvent <= 1'b0;
    end
  end

endmodule // trig_rescaler

// ### tb/trig_source_model.sv
/*
  Far-side trigger source: encoder pin and CC1 line.
  Assumes one bench process calls its tasks.
*/
`timescale 1ns/100ps

module trig_source_model
(
  input wire logic sys_clk,
  output logic trigPin,
  output logic cc1Pin
);
  // both lines idle low
  initial
  begin
    trigPin = 1'b0;
    cc1Pin = 1'b0;
  end

  // one pulse on the chosen line, then idle
  task automatic pulse(input bit onCc1, input int width);
    @(posedge sys_clk);
    cc1Pin <= onCc1;
    trigPin <= !onCc1;
    repeat (width) @(posedge sys_clk);
    cc1Pin <= 1'b0;
    trigPin <= 1'b0;
    repeat (300) @(posedge sys_clk);
  endtask

  // encoder-like square wave, period within the limit
  task automatic toggle(input int half, input int n);
    repeat (n)
    begin
      repeat (half) @(posedge sys_clk);
      trigPin <= !trigPin;
    end
  endtask
endmodule // trig_source_model

// ### tb/line_trig_chk.sv
/*
  Port checker for the line-start trigger block.
  Assumes it is bound to the top module; one clock.
*/
`timescale 1ns/100ps

module line_trig_chk
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic trigPin,
  input wire logic cc1Pin,
  input wire logic lineStart,
  input wire logic strobeOut
);
  logic [4:0] ctrl_ff;
  logic [23:0] lp_ff, mp_ff, sw_ff, gap_ff, hi_ff;
  logic [8:0] since_ff;
  logic selPrev_ff, steady_ff;
  // selected pin and trigger-mode qualifiers
  wire logic sel = ctrl_ff[1] ? cc1Pin : trigPin;
  wire logic trg = ctrl_ff[0] & ~ctrl_ff[4];
  wire logic cfgWr = regWr & (regAddr == trig_pkg::CTRL_OFS | regAddr == trig_pkg::LINE_PERIOD_OFS
    | regAddr == trig_pkg::MIN_PERIOD_OFS);

  // shadow of the registers the checks depend on
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl_ff <= 5'h00;
      lp_ff <= trig_pkg::LINE_PERIOD_RST;
      mp_ff <= trig_pkg::MIN_PERIOD_RST;
      sw_ff <= trig_pkg::STROBE_WIDTH_RST;
    end
    else if (regWr)
    begin
      if (regAddr == trig_pkg::CTRL_OFS)
        ctrl_ff <= regWdata[4:0];
      if (regAddr == trig_pkg::LINE_PERIOD_OFS)
        lp_ff <= regWdata[23:0];
      if (regAddr == trig_pkg::MIN_PERIOD_OFS)
        mp_ff <= regWdata[23:0];
      if (regAddr == trig_pkg::STROBE_WIDTH_OFS)
        sw_ff <= regWdata[23:0];
    end
  end

  // run lengths; steady means a full period passed untouched
  always_ff @(posedge sys_clk)
  begin
    selPrev_ff <= sel;
    steady_ff <= !rst && !cfgWr && !ctrl_ff[0] && (steady_ff | lineStart);
    if (rst)
    begin
      since_ff <= 9'h000;
      gap_ff <= 24'h000000;
      hi_ff <= 24'h000000;
    end
    else
    begin
      since_ff <= (sel != selPrev_ff) ? 9'h000 : since_ff + {8'h00, since_ff != 9'h1ff};
      gap_ff <= lineStart ? 24'h000000 : gap_ff + 24'h000001;
      hi_ff <= strobeOut ? hi_ff + 24'h000001 : 24'h000000;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // ******************
  // properties
  // ******************
  property p_filter;
    lineStart && trg && $past(trg, 3) |-> since_ff >= 9'h0f0;
  endproperty
  a_filter: assert property (p_filter) else $error("line start from a short pulse");
  property p_latency;
    lineStart && trg && $past(trg, 3) |-> since_ff <= 9'h106;
  endproperty
  a_latency: assert property (p_latency) else $error("line start without a recent edge");
  property p_edge;
    lineStart && trg && $past(trg, 3) |-> ctrl_ff[3:2] == 2'h2 || sel == (ctrl_ff[3:2] != 2'h1);
  endproperty
  a_edge: assert property (p_edge) else $error("line start on the wrong edge");
  property p_free;
    lineStart && steady_ff && lp_ff >= mp_ff |-> gap_ff == lp_ff - 24'h000001;
  endproperty
  a_free: assert property (p_free) else $error("free-run period wrong");
  property p_clamp;
    lineStart && steady_ff && lp_ff < mp_ff |-> gap_ff == mp_ff - 24'h000001;
  endproperty
  a_clamp: assert property (p_clamp) else $error("free-run rate not clamped");
  property p_stb_start;
    lineStart && sw_ff != 24'h000000 |=> strobeOut;
  endproperty
  a_stb_start: assert property (p_stb_start) else $error("strobe did not follow line start");
  property p_stb_width;
    $fell(strobeOut) |-> hi_ff == sw_ff;
  endproperty
  a_stb_width: assert property (p_stb_width) else $error("strobe width wrong");
  property p_pulse;
    lineStart |=> !lineStart;
  endproperty
  a_pulse: assert property (p_pulse) else $error("line start longer than one cycle");
  property p_rd_idle;
    !regRd |=> regRdata == 32'h00000000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");

  c_trig: cover property (lineStart && trg);
  c_rsc: cover property (lineStart && ctrl_ff[0] && ctrl_ff[4]);
  c_stb: cover property ($fell(strobeOut));
endmodule // line_trig_chk

bind line_start_trigger line_trig_chk chk_u (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .trigPin(trigPin),
  .cc1Pin(cc1Pin), .lineStart(lineStart), .strobeOut(strobeOut));

// ### tb/tb_top.sv
/*
  Self-checking bench: registers, free run, triggers, rescaler.
  Assumes the source model and bound checker are compiled.
*/
`timescale 1ns/100ps
`define CHECK_EQ(g, e) cmpVal((g), (e))

module tb_top;
  logic sys_clk, rst, regWr, regRd;
  logic [7:0] regAddr;
  logic [31:0] regWdata, rdVal, v1;
  wire logic [31:0] regRdata;
  wire logic trigPin, cc1Pin, lineStart, strobeOut;
  int num_errors = 0, num_checks = 0, seed = 19, lsCount = 0, base, lp, w, gap, d;
  logic [7:0] rstAddr [6] = '{trig_pkg::CTRL_OFS, trig_pkg::LINE_PERIOD_OFS, trig_pkg::MIN_PERIOD_OFS,
    trig_pkg::RESCALE_RATE_OFS, trig_pkg::STROBE_WIDTH_OFS, 8'h1c};
  logic [31:0] rstVal [6] = '{32'h0, {8'h0, trig_pkg::LINE_PERIOD_RST}, {8'h0, trig_pkg::MIN_PERIOD_RST},
    {9'h0, trig_pkg::RATE_RST}, {8'h0, trig_pkg::STROBE_WIDTH_RST}, 32'h0};
  logic [31:0] rateIn [3];

  line_start_trigger dut_u (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .trigPin(trigPin), .cc1Pin(cc1Pin),
    .lineStart(lineStart), .strobeOut(strobeOut));
  trig_source_model srcU (.sys_clk(sys_clk), .trigPin(trigPin), .cc1Pin(cc1Pin));

  // 250 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // count line starts as they happen
  always @(posedge sys_clk)
  begin
    if (lineStart === 1'b1)
      lsCount++;
  end

  // ******************
  // helpers
  // ******************
  function automatic int expEdges(input int a);
    return (a == 2) ? 2 : 1;
  endfunction
  function automatic logic [31:0] expRate(input logic [31:0] v);
    return (v < trig_pkg::RATE_MIN) ? trig_pkg::RATE_MIN : (v > trig_pkg::RATE_MAX) ? trig_pkg::RATE_MAX : v;
  endfunction
  task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  // data stand in the cycle after the strobe only
  task automatic rdReg(input logic [7:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(posedge sys_clk);
    rdVal = regRdata;
  endtask
  // bounded wait; gap holds cycles since the call
  task automatic waitLs();
    gap = 0;
    do
    begin
      @(posedge sys_clk);
      gap++;
    end
    while (lineStart !== 1'b1 && gap < 30000);
  endtask

  // watchdog: whole run is about 40k cycles
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    num_errors++;
    test_done();
  end

  // main sequence
  initial
  begin
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    wrReg(8'h1c, $random(seed));
    for (int i = 0; i < 6; i++)
    begin
      rdReg(rstAddr[i]);
      `CHECK_EQ(rdVal, rstVal[i]);
    end
    wrReg(trig_pkg::STROBE_WIDTH_OFS, 32'h5);
    wrReg(trig_pkg::MIN_PERIOD_OFS, 32'h2);
    for (int i = 0; i < 4; i++)
    begin
      lp = 10 + ($unsigned($random(seed)) % 40);
      wrReg(trig_pkg::LINE_PERIOD_OFS, lp);
      repeat (3) waitLs();
      `CHECK_EQ(gap, lp);
    end
    wrReg(trig_pkg::MIN_PERIOD_OFS, 32'h50);
    repeat (3) waitLs();
    `CHECK_EQ(gap, 32'h50);
    rdReg(trig_pkg::LINE_COUNT_OFS);
    v1 = rdVal;
    repeat (3) waitLs();
    rdReg(trig_pkg::LINE_COUNT_OFS);
    `CHECK_EQ(rdVal - v1, 3);
    for (int c = 0; c < 8; c++)
    begin
      wrReg(trig_pkg::CTRL_OFS, c << trig_pkg::CTRL_FILT_LSB);
      rdReg(trig_pkg::CTRL_OFS);
      `CHECK_EQ(rdVal, (c > trig_pkg::FILT_MAX ? trig_pkg::FILT_MAX : c) << trig_pkg::CTRL_FILT_LSB);
    end
    rateIn = '{32'h0, $unsigned($random(seed)) % 32'h00700000, 32'hffffffff};
    for (int i = 0; i < 3; i++)
    begin
      wrReg(trig_pkg::RESCALE_RATE_OFS, rateIn[i]);
      rdReg(trig_pkg::RESCALE_RATE_OFS);
      `CHECK_EQ(rdVal, expRate(rateIn[i]));
    end
    // every source and activation code, plus refused pulses
    for (int s = 0; s < 2; s++)
    begin
      for (int a = 0; a < 4; a++)
      begin
        wrReg(trig_pkg::CTRL_OFS, 1 | (s << trig_pkg::CTRL_SRC_BIT) | (a << trig_pkg::CTRL_ACT_LSB));
        repeat (300) @(posedge sys_clk);
        base = lsCount;
        w = 260 + ($unsigned($random(seed)) % 100);
        srcU.pulse(s[0], w);
        `CHECK_EQ(lsCount - base, expEdges(a));
        base = lsCount;
        srcU.pulse(!s[0], w);
        `CHECK_EQ(lsCount - base, 0);
        srcU.pulse(s[0], 249); // one cycle short of the filter
        `CHECK_EQ(lsCount - base, 0);
      end
    end
    // rescaler at 2.0 on a 300-cycle input period; any filter code must settle there
    wrReg(trig_pkg::RESCALE_RATE_OFS, 32'h00020000);
    wrReg(trig_pkg::CTRL_OFS, 32'h19 | (($unsigned($random(seed)) % 6) << trig_pkg::CTRL_FILT_LSB));
    srcU.toggle(300, 40);
    base = lsCount;
    srcU.toggle(300, 20);
    d = lsCount - base;
    `CHECK_EQ(d >= 38 && d <= 42, 1'b1);
    rdReg(trig_pkg::AVG_PERIOD_OFS);
    `CHECK_EQ(rdVal >= 298 && rdVal <= 302, 1'b1);
    wrReg(trig_pkg::CTRL_OFS, 32'h09);
    repeat (300) @(posedge sys_clk);
    base = lsCount;
    srcU.toggle(300, 4);
    repeat (300) @(posedge sys_clk);
    `CHECK_EQ(lsCount - base, 4);
    test_done();
  end
endmodule // tb_top
